/* File: src/lpio_top.sv */
`timescale 1ns/10ps
module lpio_top
	import lpio_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [lpio_pkg::LPIO_ADDR_W-1:0] paddr_i,
	input wire logic [lpio_pkg::LPIO_DATA_W-1:0] pwdata_i,
	output logic [lpio_pkg::LPIO_DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// First port pins.
	output logic [lpio_pkg::LPIO_PORT_W-1:0] first_port_pins_o,
	// Second port pins.
	input wire logic [lpio_pkg::LPIO_PORT_W-1:0] second_port_pins_i,
	output logic [lpio_pkg::LPIO_PORT_W-1:0] second_port_pins_o,
	output logic [lpio_pkg::LPIO_PORT_W-1:0] second_port_pins_oe_o,
	// Third port pins.
	input wire logic [lpio_pkg::LPIO_PORT_W-1:0] third_port_pins_i,
	output logic [lpio_pkg::LPIO_PORT_W-1:0] third_port_pins_o,
	output logic [lpio_pkg::LPIO_PORT_W-1:0] third_port_pins_oe_o,
	// Control functions routed through the third port.
	input wire logic serial_acknowledge_i,
	input wire logic timer_flop_out_i,
	input wire logic io_cycle_i,
	input wire logic bus_release_grant_i,
	output logic serial_chip_select_n_o,
	output logic bus_hold_request_o
);
	import lpio_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks on the shared constants.
	// Counts the registers that claim one offset, so that two on one word are refused.
	function automatic int unsigned off_uses(input logic [7:0] off);
		off_uses = 0;
		if (off == LPIO_OFF_PA_DATA)
			off_uses = off_uses + 1;
		if (off == LPIO_OFF_PA_ALU)
			off_uses = off_uses + 1;
		if (off == LPIO_OFF_PB_DATA)
			off_uses = off_uses + 1;
		if (off == LPIO_OFF_PB_DIR)
			off_uses = off_uses + 1;
		if (off == LPIO_OFF_PC_DATA)
			off_uses = off_uses + 1;
		if (off == LPIO_OFF_PC_FSEL)
			off_uses = off_uses + 1;
		if (off == LPIO_OFF_PC_STAT)
			off_uses = off_uses + 1;
	endfunction : off_uses

	// The port logic is written for byte-wide ports on a word-wide bus.
	if (LPIO_PORT_W != 8)
		$error("lpio_top: LPIO_PORT_W must be 8");
	if (LPIO_ADDR_W != 8)
		$error("lpio_top: LPIO_ADDR_W must be 8");
	if (LPIO_DATA_W != 32)
		$error("lpio_top: LPIO_DATA_W must be 32");
	// The op field sits above the operand byte and inside the write word.
	if (LPIO_ALU_OP_LSB < LPIO_PORT_W || LPIO_ALU_OP_LSB + 3 > LPIO_DATA_W)
		$error("lpio_top: LPIO_ALU_OP_LSB out of range");
	// Function pins sit in order on pins 2 to 7, the six whose functions the mode register selects.
	if (LPIO_PC_CSEL_BIT != 2 || LPIO_PC_HOLD_BIT >= LPIO_PORT_W)
		$error("lpio_top: third port function bits out of range");
	if (LPIO_PC_SACK_BIT != LPIO_PC_CSEL_BIT + 1 ||
		LPIO_PC_TMR_BIT != LPIO_PC_SACK_BIT + 1 ||
		LPIO_PC_IOM_BIT != LPIO_PC_TMR_BIT + 1 ||
		LPIO_PC_GRANT_BIT != LPIO_PC_IOM_BIT + 1 ||
		LPIO_PC_HOLD_BIT != LPIO_PC_GRANT_BIT + 1)
		$error("lpio_top: third port function bits out of order");
	if (LPIO_STAT_CSEL_BIT == LPIO_STAT_HOLD_BIT || LPIO_STAT_HOLD_BIT >= LPIO_PORT_W)
		$error("lpio_top: status bits clash or out of range");
	// Each register takes one aligned word of its own.
	if (((LPIO_OFF_PA_DATA | LPIO_OFF_PA_ALU | LPIO_OFF_PB_DATA | LPIO_OFF_PB_DIR |
		LPIO_OFF_PC_DATA | LPIO_OFF_PC_FSEL | LPIO_OFF_PC_STAT) & 8'h03) != 8'h00)
		$error("lpio_top: register offsets must be word aligned");
	if (off_uses(LPIO_OFF_PA_DATA) != 1 || off_uses(LPIO_OFF_PA_ALU) != 1 ||
		off_uses(LPIO_OFF_PB_DATA) != 1 || off_uses(LPIO_OFF_PB_DIR) != 1 ||
		off_uses(LPIO_OFF_PC_DATA) != 1 || off_uses(LPIO_OFF_PC_FSEL) != 1 ||
		off_uses(LPIO_OFF_PC_STAT) != 1)
		$error("lpio_top: two registers share an offset");

	////////////////////////////////////////////////////////////////////////////////
	// Register bus.
	lpio_reg_if reg_bus ();

	lpio_apb_slave u_apb
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.reg_bus(reg_bus.bus)
	);

	logic wr_pa_data;
	logic wr_pa_alu;
	logic wr_pb_data;
	logic wr_pb_dir;
	logic wr_pc_data;
	logic wr_pc_fsel;
	logic [7:0] wbyte;
	logic [2:0] alu_op;

	// A register strobe is an access-phase write to that register's own offset.
	function automatic logic wr_hit(input logic wr_en, input logic [7:0] addr,
		input logic [7:0] off);
		wr_hit = wr_en && addr == off;
	endfunction : wr_hit

	assign wr_pa_data = wr_hit(reg_bus.wr_en, reg_bus.addr, LPIO_OFF_PA_DATA);
	assign wr_pa_alu = wr_hit(reg_bus.wr_en, reg_bus.addr, LPIO_OFF_PA_ALU);
	assign wr_pb_data = wr_hit(reg_bus.wr_en, reg_bus.addr, LPIO_OFF_PB_DATA);
	assign wr_pb_dir = wr_hit(reg_bus.wr_en, reg_bus.addr, LPIO_OFF_PB_DIR);
	assign wr_pc_data = wr_hit(reg_bus.wr_en, reg_bus.addr, LPIO_OFF_PC_DATA);
	assign wr_pc_fsel = wr_hit(reg_bus.wr_en, reg_bus.addr, LPIO_OFF_PC_FSEL);
	assign wbyte = reg_bus.wdata[7:0];
	assign alu_op = reg_bus.wdata[LPIO_ALU_OP_LSB +: 3];

	////////////////////////////////////////////////////////////////////////////////
	// First port: output-only latch.
	logic [7:0] pa_latch_ff;
	logic [7:0] nxt_pa_latch;

	// A data write replaces the latch; an ALU write applies the op field to the latch and operand, and ops 6 and 7 leave it unchanged.
	always_comb
	begin
		nxt_pa_latch = pa_latch_ff;
		if (wr_pa_data)
			nxt_pa_latch = wbyte;
		else if (wr_pa_alu)
			nxt_pa_latch = lpio_alu(alu_op, pa_latch_ff, wbyte);
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pa_latch_ff <= LPIO_RST_PA_DATA;
		else
			pa_latch_ff <= nxt_pa_latch;
	end

	assign first_port_pins_o = pa_latch_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Second port: per-bit direction.
	logic [7:0] pb_out_ff;
	logic [7:0] pb_dir_ff;
	logic [7:0] pb_rd;

	// The output latch takes writes in either direction; a pin turned to output drives it.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pb_out_ff <= LPIO_RST_PB_DATA;
		else if (wr_pb_data)
			pb_out_ff <= wbyte;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pb_dir_ff <= LPIO_RST_PB_DIR;
		else if (wr_pb_dir)
			pb_dir_ff <= wbyte;
	end

	lpio_pin_latch #(
		.WIDTH(LPIO_PORT_W)
	) u_port_b
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.out_val_i(pb_out_ff),
		.dir_in_i(pb_dir_ff),
		.pin_lat_o(),
		.rd_val_o(pb_rd),
		.pins_i(second_port_pins_i),
		.pins_o(second_port_pins_o),
		.pins_oe_o(second_port_pins_oe_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Third port: plain I/O or control functions by mode bit.
	logic [7:0] pc_out_ff;
	logic [7:0] pc_fsel_ff;
	logic [7:0] pc_dir_in;
	logic [7:0] pc_drive;
	logic [7:0] pc_pin_lat;
	logic [7:0] pc_rd;

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pc_out_ff <= LPIO_RST_PC_DATA;
		else if (wr_pc_data)
			pc_out_ff <= wbyte;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pc_fsel_ff <= LPIO_RST_PC_FSEL;
		else if (wr_pc_fsel)
			pc_fsel_ff <= wbyte;
	end

	// Pins 2 and 7 are always inputs, pins 3 to 6 always outputs.
	always_comb
	begin
		pc_dir_in = 8'h00;
		pc_dir_in[0] = pc_fsel_ff[0];
		pc_dir_in[1] = pc_fsel_ff[1];
		pc_dir_in[LPIO_PC_CSEL_BIT] = 1'b1;
		pc_dir_in[LPIO_PC_HOLD_BIT] = 1'b1;
	end

	// Pins in function mode carry the control signal in place of the latch.
	always_comb
	begin
		pc_drive = pc_out_ff;
		if (!pc_fsel_ff[LPIO_PC_SACK_BIT])
			pc_drive[LPIO_PC_SACK_BIT] = serial_acknowledge_i;
		if (!pc_fsel_ff[LPIO_PC_TMR_BIT])
			pc_drive[LPIO_PC_TMR_BIT] = timer_flop_out_i;
		if (!pc_fsel_ff[LPIO_PC_IOM_BIT])
			pc_drive[LPIO_PC_IOM_BIT] = io_cycle_i;
		if (!pc_fsel_ff[LPIO_PC_GRANT_BIT])
			pc_drive[LPIO_PC_GRANT_BIT] = bus_release_grant_i;
	end

	lpio_pin_latch #(
		.WIDTH(LPIO_PORT_W)
	) u_port_c
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.out_val_i(pc_drive),
		.dir_in_i(pc_dir_in),
		.pin_lat_o(pc_pin_lat),
		.rd_val_o(pc_rd),
		.pins_i(third_port_pins_i),
		.pins_o(third_port_pins_o),
		.pins_oe_o(third_port_pins_oe_o)
	);

	// Functions not selected rest inactive so the serial and bus blocks see no stray request.
	assign serial_chip_select_n_o = pc_fsel_ff[LPIO_PC_CSEL_BIT] |
		pc_pin_lat[LPIO_PC_CSEL_BIT];
	assign bus_hold_request_o = ~pc_fsel_ff[LPIO_PC_HOLD_BIT] &
		pc_pin_lat[LPIO_PC_HOLD_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Read multiplexer.
	// Reads decode straight from the address so that the slave can flop them at setup.
	always_comb
	begin
		reg_bus.rdata = 32'h0000_0000;
		case (reg_bus.addr)
			LPIO_OFF_PA_DATA: reg_bus.rdata[7:0] = pa_latch_ff;
			LPIO_OFF_PA_ALU: reg_bus.rdata[7:0] = pa_latch_ff;
			LPIO_OFF_PB_DATA: reg_bus.rdata[7:0] = pb_rd;
			LPIO_OFF_PB_DIR: reg_bus.rdata[7:0] = pb_dir_ff;
			LPIO_OFF_PC_DATA: reg_bus.rdata[7:0] = pc_rd;
			LPIO_OFF_PC_FSEL: reg_bus.rdata[7:0] = pc_fsel_ff;
			// Status shows the chip select and hold request outputs after their mode gating.
			LPIO_OFF_PC_STAT:
			begin
				reg_bus.rdata[LPIO_STAT_CSEL_BIT] = serial_chip_select_n_o;
				reg_bus.rdata[LPIO_STAT_HOLD_BIT] = bus_hold_request_o;
			end
			default: reg_bus.rdata = 32'h0000_0000;
		endcase
	end
endmodule : lpio_top

/* File: shared/lpio_pkg.sv */
package lpio_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths.
	localparam int unsigned LPIO_PORT_W = 8;
	localparam int unsigned LPIO_ADDR_W = 8;
	localparam int unsigned LPIO_DATA_W = 32;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets.
	localparam logic [7:0] LPIO_OFF_PA_DATA = 8'h00;
	localparam logic [7:0] LPIO_OFF_PA_ALU = 8'h04;
	localparam logic [7:0] LPIO_OFF_PB_DATA = 8'h08;
	localparam logic [7:0] LPIO_OFF_PB_DIR = 8'h0c;
	localparam logic [7:0] LPIO_OFF_PC_DATA = 8'h10;
	localparam logic [7:0] LPIO_OFF_PC_FSEL = 8'h14;
	localparam logic [7:0] LPIO_OFF_PC_STAT = 8'h18;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [7:0] LPIO_RST_PA_DATA = 8'h00;
	localparam logic [7:0] LPIO_RST_PB_DATA = 8'h00;
	localparam logic [7:0] LPIO_RST_PB_DIR = 8'hff;
	localparam logic [7:0] LPIO_RST_PC_DATA = 8'h00;
	localparam logic [7:0] LPIO_RST_PC_FSEL = 8'hff;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int unsigned LPIO_PC_CSEL_BIT = 2;
	localparam int unsigned LPIO_PC_SACK_BIT = 3;
	localparam int unsigned LPIO_PC_TMR_BIT = 4;
	localparam int unsigned LPIO_PC_IOM_BIT = 5;
	localparam int unsigned LPIO_PC_GRANT_BIT = 6;
	localparam int unsigned LPIO_PC_HOLD_BIT = 7;
	localparam int unsigned LPIO_ALU_OP_LSB = 8;
	localparam int unsigned LPIO_STAT_CSEL_BIT = 0;
	localparam int unsigned LPIO_STAT_HOLD_BIT = 1;

	typedef enum logic [2:0] {
		LPIO_ALU_LOAD = 3'h0,
		LPIO_ALU_AND = 3'h1,
		LPIO_ALU_OR = 3'h2,
		LPIO_ALU_XOR = 3'h3,
		LPIO_ALU_ADD = 3'h4,
		LPIO_ALU_SUB = 3'h5
	} lpio_alu_op_t;

	function automatic logic lpio_is_mapped(input logic [7:0] addr);
		case (addr)
			LPIO_OFF_PA_DATA, LPIO_OFF_PA_ALU, LPIO_OFF_PB_DATA, LPIO_OFF_PB_DIR,
			LPIO_OFF_PC_DATA, LPIO_OFF_PC_FSEL, LPIO_OFF_PC_STAT: lpio_is_mapped = 1'b1;
			default: lpio_is_mapped = 1'b0;
		endcase
	endfunction : lpio_is_mapped

	function automatic logic [7:0] lpio_alu(input logic [2:0] op, input logic [7:0] a,
		input logic [7:0] b);
		case (op)
			LPIO_ALU_LOAD: lpio_alu = b;
			LPIO_ALU_AND: lpio_alu = a & b;
			LPIO_ALU_OR: lpio_alu = a | b;
			LPIO_ALU_XOR: lpio_alu = a ^ b;
			LPIO_ALU_ADD: lpio_alu = 8'(a + b);
			LPIO_ALU_SUB: lpio_alu = 8'(a - b);
			default: lpio_alu = a;
		endcase
	endfunction : lpio_alu

endpackage : lpio_pkg

/* File: shared/lpio_reg_if.sv */
`timescale 1ns/10ps
interface lpio_reg_if;
	logic [7:0] addr;
	logic wr_en;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport bus
	(
		output addr,
		output wr_en,
		output wdata,
		input rdata
	);

	modport core
	(
		input addr,
		input wr_en,
		input wdata,
		output rdata
	);
endinterface : lpio_reg_if

/* File: src/lpio_apb_slave.sv */
`timescale 1ns/10ps
module lpio_apb_slave
	import lpio_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// APB slave side.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [lpio_pkg::LPIO_ADDR_W-1:0] paddr_i,
	input wire logic [lpio_pkg::LPIO_DATA_W-1:0] pwdata_i,
	output logic [lpio_pkg::LPIO_DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Register side.
	lpio_reg_if.bus reg_bus
);
	import lpio_pkg::*;

	logic setup_phase;
	logic access_phase;
	logic mapped;
	logic [31:0] prdata_ff;

	assign setup_phase = psel_i & ~penable_i;
	assign access_phase = psel_i & penable_i;
	assign mapped = lpio_is_mapped(paddr_i);

	assign reg_bus.addr = paddr_i;
	assign reg_bus.wdata = pwdata_i;
	assign reg_bus.wr_en = access_phase & pwrite_i & mapped;

	// Read data is captured in the setup cycle so it comes from a flop in the access cycle.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			prdata_ff <= 32'h0000_0000;
		else if (setup_phase && !pwrite_i)
			prdata_ff <= mapped ? reg_bus.rdata : 32'h0000_0000;
	end

	assign prdata_o = prdata_ff;
	assign pready_o = 1'b1;
	assign pslverr_o = access_phase & ~mapped;
endmodule : lpio_apb_slave

/* File: src/lpio_pin_latch.sv */
`timescale 1ns/10ps
module lpio_pin_latch #(
	parameter int unsigned WIDTH = 8
)
(
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Internal side.
	input wire logic [WIDTH-1:0] out_val_i,
	input wire logic [WIDTH-1:0] dir_in_i,
	output logic [WIDTH-1:0] pin_lat_o,
	output logic [WIDTH-1:0] rd_val_o,
	// Pins.
	input wire logic [WIDTH-1:0] pins_i,
	output logic [WIDTH-1:0] pins_o,
	output logic [WIDTH-1:0] pins_oe_o
);
	logic [WIDTH-1:0] in_lat_ff;

	if (WIDTH < 1 || WIDTH > 32)
		$error("lpio_pin_latch: WIDTH must be 1 to 32");

	// Input levels are held in a latch every clock, whatever the direction.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			in_lat_ff <= '0;
		else
			in_lat_ff <= pins_i;
	end

	assign pins_o = out_val_i;
	assign pins_oe_o = ~dir_in_i;
	assign pin_lat_o = in_lat_ff;
	assign rd_val_o = (dir_in_i & in_lat_ff) | (~dir_in_i & out_val_i);
endmodule : lpio_pin_latch

/* File: testbench/lpio_top_monitor.sv */
`timescale 1ns/10ps
module lpio_top_monitor
	import lpio_pkg::*;
(
	// Clock, reset and bus.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [lpio_pkg::LPIO_ADDR_W-1:0] paddr_i,
	// Pins.
	input wire logic [lpio_pkg::LPIO_PORT_W-1:0] first_port_pins_o,
	input wire logic [lpio_pkg::LPIO_PORT_W-1:0] second_port_pins_o,
	input wire logic [lpio_pkg::LPIO_PORT_W-1:0] second_port_pins_oe_o,
	input wire logic [lpio_pkg::LPIO_PORT_W-1:0] third_port_pins_i,
	input wire logic [lpio_pkg::LPIO_PORT_W-1:0] third_port_pins_oe_o,
	input wire logic serial_chip_select_n_o,
	input wire logic bus_hold_request_o
);
	logic wr;
	assign wr = psel_i & penable_i & pwrite_i;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_pa_holds_value: assert property ($changed(first_port_pins_o) |->
		$past(wr && (paddr_i == LPIO_OFF_PA_DATA || paddr_i == LPIO_OFF_PA_ALU)))
		else $error("first port changed without a write");
	a_pb_latch_holds: assert property ($changed(second_port_pins_o) |->
		$past(wr && paddr_i == LPIO_OFF_PB_DATA)) else $error("second port latch moved");
	a_pb_dir_holds: assert property ($changed(second_port_pins_oe_o) |->
		$past(wr && paddr_i == LPIO_OFF_PB_DIR)) else $error("second port enable moved");
	a_pc_low_dir: assert property ($changed(third_port_pins_oe_o[1:0]) |->
		$past(wr && paddr_i == LPIO_OFF_PC_FSEL)) else $error("third port enable moved");
	a_pc_fixed_dir: assert property (third_port_pins_oe_o[7:2] == 6'h1e)
		else $error("third port upper enables wrong");
	a_cs_follows_pin: assert property (!serial_chip_select_n_o |->
		!$past(third_port_pins_i[2])) else $error("chip select without pin low");
	a_hold_follows_pin: assert property (bus_hold_request_o |->
		$past(third_port_pins_i[7])) else $error("hold request without pin high");
	a_reset_dirs: assert property (disable iff (1'b0) !rst_n_i |->
		second_port_pins_oe_o == 8'h00 && third_port_pins_oe_o == 8'h78)
		else $error("reset directions wrong");
endmodule : lpio_top_monitor

bind lpio_top lpio_top_monitor u_mon (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .first_port_pins_o, .second_port_pins_o, .second_port_pins_oe_o,
	.third_port_pins_i, .third_port_pins_oe_o, .serial_chip_select_n_o, .bus_hold_request_o);

/* File: testbench/lpio_pins_model.sv */
`timescale 1ns/10ps
module lpio_pins_model
(
	// Clock.
	input wire logic clk_i,
	// Device side and board drive.
	input wire logic [7:0] pins_o_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] drv_i,
	input wire logic [7:0] drv_en_i,
	output logic [7:0] pins_i_o
);
	logic [7:0] last_ff;
	always_ff @(posedge clk_i) last_ff <= pins_i_o;
	// A pin nobody drives shows a changing level rather than a stale one.
	always_comb pins_i_o = (oe_i & pins_o_i) | (~oe_i & drv_en_i & drv_i)
		| (~oe_i & ~drv_en_i & ~last_ff);
endmodule : lpio_pins_model

/* File: testbench/test_lpio_top.sv */
`timescale 1ns/10ps
module test_lpio_top;
	import lpio_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o, rd;
	logic pready_o, pslverr_o, err, cs_n, hold;
	logic [7:0] pa_o, pb_i, pb_o, pb_oe, pc_i, pc_o, pc_oe;
	logic [7:0] pb_ext = 8'h00;
	logic [7:0] pc_ext = 8'h00;
	logic [3:0] fn = 4'h0;
	int err_count = 0;
	int checks_done = 0;
	int pa, pb, dir, pc, mode, op, v, e, m, inm, drv;
	always #4 core_clk_i = ~core_clk_i;
	lpio_top dut (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .first_port_pins_o(pa_o), .second_port_pins_i(pb_i),
		.second_port_pins_o(pb_o), .second_port_pins_oe_o(pb_oe), .third_port_pins_i(pc_i),
		.third_port_pins_o(pc_o), .third_port_pins_oe_o(pc_oe), .serial_acknowledge_i(fn[0]),
		.timer_flop_out_i(fn[1]), .io_cycle_i(fn[2]), .bus_release_grant_i(fn[3]),
		.serial_chip_select_n_o(cs_n), .bus_hold_request_o(hold));
	lpio_pins_model u_pb (.clk_i(core_clk_i), .pins_o_i(pb_o), .oe_i(pb_oe), .drv_i(pb_ext),
		.drv_en_i(8'hff), .pins_i_o(pb_i));
	lpio_pins_model u_pc (.clk_i(core_clk_i), .pins_o_i(pc_o), .oe_i(pc_oe), .drv_i(pc_ext),
		.drv_en_i(8'hff), .pins_i_o(pc_i));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		@(posedge core_clk_i);
		while (pready_o !== 1'b1)
			@(posedge core_clk_i);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input int exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, "read");
	endtask : rdchk
	task automatic results();
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	initial
	begin
		#100000;
		err_count++;
		results();
	end
	initial
	begin
		void'($urandom(32'hc86e207f));
		rst_n_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		pa = 0;
		rdchk(LPIO_OFF_PB_DIR, 8'hff);
		rdchk(LPIO_OFF_PC_FSEL, 8'hff);
		chk(pc_o & pc_oe, 8'h00, "pc_o");
		for (int i = 0; i < 16; i++)
		begin
			op = i % 8;
			v = $urandom_range(255);
			apb(1'b1, (op == 7) ? LPIO_OFF_PA_DATA : LPIO_OFF_PA_ALU, (op << 8) | v);
			chk(err, 1'b0, "slverr");
			case (op)
				0, 7: pa = v;
				1: pa = pa & v;
				2: pa = pa | v;
				3: pa = pa ^ v;
				4: pa = (pa + v) & 255;
				5: pa = (pa - v) & 255;
				default: pa = pa;
			endcase
			apb(1'b1, 8'h1c, $urandom_range(255));
			chk(err, 1'b1, "slverr");
			#1 chk(pa_o, pa, "pa_o");
			rdchk(LPIO_OFF_PA_DATA, pa);
			rdchk(LPIO_OFF_PA_ALU, pa);
		end
		rdchk(8'h1c, 0);
		for (int i = 0; i < 8; i++)
		begin
			dir = $urandom_range(255);
			pb = $urandom_range(255);
			e = $urandom_range(255);
			apb(1'b1, LPIO_OFF_PB_DIR, dir);
			apb(1'b1, LPIO_OFF_PB_DATA, pb);
			pb_ext <= e[7:0];
			@(posedge core_clk_i);
			#1 chk(pb_oe, ~dir & 255, "pb_oe");
			chk(pb_o, pb, "pb_o");
			rdchk(LPIO_OFF_PB_DATA, (dir & e) | (~dir & pb & 255));
		end
		for (int i = 0; i < 8; i++)
		begin
			mode = (i == 0) ? 0 : (i == 1) ? 255 : $urandom_range(255);
			pc = $urandom_range(255);
			e = $urandom_range(255);
			v = $urandom_range(15);
			apb(1'b1, LPIO_OFF_PC_FSEL, mode);
			apb(1'b1, LPIO_OFF_PC_DATA, pc);
			pc_ext <= e[7:0];
			fn <= v[3:0];
			repeat (2) @(posedge core_clk_i);
			m = ~mode & 8'h78;
			drv = (pc & ~m) | ((v << 3) & m);
			inm = 8'h84 | (mode & 3);
			#1 chk(pc_oe, ~inm & 255, "pc_oe");
			chk(pc_o & pc_oe, drv & ~inm & 255, "pc_o");
			chk(cs_n, mode[2] | e[2], "cs_n");
			chk(hold, ~mode[7] & e[7], "hold");
			rdchk(LPIO_OFF_PC_DATA, (inm & e) | (~inm & drv & 255));
			rdchk(LPIO_OFF_PC_STAT, {~mode[7] & e[7], mode[2] | e[2]});
		end
		rst_n_i <= 1'b0;
		@(posedge core_clk_i);
		#1 chk(pa_o, 8'h00, "pa_o");
		chk(pb_oe, 8'h00, "pb_oe");
		chk(pc_oe, 8'h78, "pc_oe");
		@(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rdchk(LPIO_OFF_PB_DIR, 8'hff);
		rdchk(LPIO_OFF_PC_FSEL, 8'hff);
		rdchk(LPIO_OFF_PA_DATA, 0);
		results();
	end
endmodule : test_lpio_top
